// >>> rtl/brc_defines.svh
// Register addresses, reset values and codes
`ifndef BRC_DEFINES_SVH
`define BRC_DEFINES_SVH

// Register addresses on the serial register port
`define BRC_ADDR_LOW_SETPOINT 8'h00
`define BRC_ADDR_HIGH_SETPOINT 8'h01
`define BRC_ADDR_CONVERTER_CONFIG 8'h02
`define BRC_ADDR_TRANSITION_STATUS 8'h03

// Supplier code, value is arbitrary
`define BRC_SUPPLIER_CODE 2'h1

// Reset values of the stored fields
`define BRC_RST_ENABLE 1'h1
`define BRC_RST_LOW_CODE 6'h18
`define BRC_RST_HIGH_CODE 6'h30
`define BRC_RST_SYNC_FOLLOW 1'h0
`define BRC_RST_PIN_SOURCE 1'h1
`define BRC_RST_MODE_POLICY 2'h0
`define BRC_RST_HIGH_MODE 1'h0
`define BRC_RST_LOW_MODE 1'h0
`define BRC_RST_TRIGGER 1'h0
`define BRC_RST_PULLDOWN 1'h0
`define BRC_RST_MULT 2'h0
`define BRC_RST_RAMP 3'h7
`define BRC_RST_GOOD 1'h0

// Fixed read value of the reserved set-point bit
`define BRC_RESERVED_BIT 1'h1

// Mode policy codes
`define BRC_POLICY_DEFER 2'h0
`define BRC_POLICY_LIGHT_AUTO 2'h1
`define BRC_POLICY_FIXED 2'h2

// Ramp code that selects single-step rising transitions
`define BRC_RAMP_SINGLE_STEP 3'h7

// Read value of an unmapped address
`define BRC_UNMAPPED_READ 8'h00

`endif

// >>> rtl/brc_pkg.sv
// Register layouts and control types of the regulator control block
package brc_pkg;

  // Set-point register layout
  typedef struct packed {
    logic converterEnableBit;
    logic reservedBit;
    logic [5:0] code;
  } brc_setpoint_t;

  // Converter configuration register layout
  typedef struct packed {
    logic [1:0] supplierCode;
    logic syncFollow;
    logic pinSourceSelect;
    logic [1:0] modePolicy;
    logic highSetpointModeBit;
    logic lowSetpointModeBit;
  } brc_config_t;

  // Transition and status register layout
  typedef struct packed {
    logic transitionTrigger;
    logic outputPulldownOnDisable;
    logic regulationGood;
    logic [1:0] syncFrequencyMultiplier;
    logic [2:0] risingRampRate;
  } brc_status_t;

  // Switching mode handed to the converter
  typedef enum logic {
    BRC_MODE_FIXED_FREQ,
    BRC_MODE_LIGHT_AUTO
  } brc_mode_t;

  // Analog-facing controls
  typedef struct packed {
    logic [5:0] setpointCode;
    brc_mode_t switchMode;
    logic syncLock;
    logic [2:0] syncMultiplier;
    logic [6:0] rampScale;
    logic rampSingleStep;
    logic converterEnable;
    logic outputPulldown;
  } brc_conv_ctrl_t;

endpackage

// >>> rtl/brc_mode_select.sv
// Switching mode and sync lock decision
`timescale 1ns/100ps
`default_nettype none
`include "brc_defines.svh"

module brc_mode_select
(
  input wire brc_pkg::brc_config_t config_in,
  input wire logic setpointSelectPin,
  input wire logic syncValid,
  output brc_pkg::brc_mode_t switchMode,
  output logic syncLock
);

  logic highDrives;
  logic syncException;
  logic lockNow;
  brc_pkg::brc_mode_t deferMode;

  // Which set point drives, and the sync exception case
  always_comb
  begin
    highDrives = !config_in.pinSourceSelect || setpointSelectPin;
    syncException = (config_in.modePolicy == `BRC_POLICY_DEFER) &&
                    !setpointSelectPin && config_in.pinSourceSelect;
    lockNow = config_in.syncFollow && syncValid && !syncException;
  end

  // Per-set-point mode bits; low mode bit is never read here
  always_comb
  begin
    if (highDrives && !config_in.highSetpointModeBit)
      deferMode = brc_pkg::BRC_MODE_FIXED_FREQ;
    else
      deferMode = brc_pkg::BRC_MODE_LIGHT_AUTO;
  end

  // Policy decode, sync lock overrides light-load
  always_comb
  begin
    syncLock = lockNow;
    if (lockNow)
      switchMode = brc_pkg::BRC_MODE_FIXED_FREQ;
    else
    begin
      case (config_in.modePolicy)
        `BRC_POLICY_LIGHT_AUTO: switchMode = brc_pkg::BRC_MODE_LIGHT_AUTO;
        `BRC_POLICY_FIXED: switchMode = brc_pkg::BRC_MODE_FIXED_FREQ;
        default: switchMode = deferMode;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> rtl/brc_ramp_map.sv
// Rising ramp and sync multiplier decode
`timescale 1ns/100ps
`default_nettype none
`include "brc_defines.svh"

module brc_ramp_map
(
  input wire logic [2:0] rampCode,
  input wire logic [1:0] multCode,
  output logic [6:0] rampScale,
  output logic rampSingleStep,
  output logic [2:0] syncMultiplier
);

  // Scale in steps of the slowest rate, doubling per code
  always_comb
  begin
    rampSingleStep = (rampCode == `BRC_RAMP_SINGLE_STEP);
    if (rampSingleStep)
      rampScale = 7'h00;
    else
      rampScale = 7'(7'h01 << rampCode);
    syncMultiplier = 3'(multCode) + 3'h1;
  end

endmodule
`default_nettype wire

// >>> rtl/brc_control_regs.sv
// Control and status register bank of the step-down regulator
`timescale 1ns/100ps
`default_nettype none
`include "brc_defines.svh"

module brc_control_regs
(
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port from the serial bus engine
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Device pins and converter status
  input wire logic setpointSelectPin,
  input wire logic enablePin,
  input wire logic syncValid,
  input wire logic inRegulation,
  input wire logic inCurrentLimit,
  // Controls to the converter
  output brc_pkg::brc_conv_ctrl_t convCtrl,
  output logic transitionStart
);

  // Stored register fields
  logic converterEnableBit;
  logic [5:0] lowCode;
  logic [5:0] highCode;
  logic syncFollow;
  logic pinSourceSelect;
  logic [1:0] modePolicy;
  logic highSetpointModeBit;
  logic lowSetpointModeBit;
  logic transitionTrigger;
  logic outputPulldownOnDisable;
  logic [1:0] syncFrequencyMultiplier;
  logic [2:0] risingRampRate;
  logic regulationGood;
  logic [5:0] appliedCode;

  logic next_converterEnableBit;
  logic [5:0] next_lowCode;
  logic [5:0] next_highCode;
  logic next_syncFollow;
  logic next_pinSourceSelect;
  logic [1:0] next_modePolicy;
  logic next_highSetpointModeBit;
  logic next_lowSetpointModeBit;
  logic next_transitionTrigger;
  logic next_outputPulldownOnDisable;
  logic [1:0] next_syncFrequencyMultiplier;
  logic [2:0] next_risingRampRate;
  logic next_regulationGood;
  logic [5:0] next_appliedCode;

  // Output registers
  logic [7:0] next_regRdata;
  brc_pkg::brc_conv_ctrl_t next_convCtrl;
  logic next_transitionStart;

  // Register images and decoded controls
  brc_pkg::brc_setpoint_t lowImage;
  brc_pkg::brc_setpoint_t highImage;
  brc_pkg::brc_config_t configImage;
  brc_pkg::brc_status_t statusImage;
  brc_pkg::brc_setpoint_t writeSetpoint;
  brc_pkg::brc_config_t writeConfig;
  brc_pkg::brc_status_t writeStatus;
  brc_pkg::brc_mode_t switchMode;
  logic syncLock;
  logic [6:0] rampScale;
  logic rampSingleStep;
  logic [2:0] syncMultiplier;
  logic triggerWrite;

  // Address match shared by the write and read paths
  function automatic logic addrIs(input logic [7:0] addr,
                                  input logic [7:0] target);
    addrIs = (addr == target);
  endfunction

  // Set-point register image with the shared enable bit
  function automatic brc_pkg::brc_setpoint_t setpointImage(
    input logic enableBit,
    input logic [5:0] code);
    setpointImage.converterEnableBit = enableBit;
    setpointImage.reservedBit = `BRC_RESERVED_BIT;
    setpointImage.code = code;
  endfunction

  // Register images as software sees them
  always_comb
  begin
    lowImage = setpointImage(converterEnableBit, lowCode);
    highImage = setpointImage(converterEnableBit, highCode);
    configImage.supplierCode = `BRC_SUPPLIER_CODE;
    configImage.syncFollow = syncFollow;
    configImage.pinSourceSelect = pinSourceSelect;
    configImage.modePolicy = modePolicy;
    configImage.highSetpointModeBit = highSetpointModeBit;
    configImage.lowSetpointModeBit = lowSetpointModeBit;
    statusImage.transitionTrigger = transitionTrigger;
    statusImage.outputPulldownOnDisable = outputPulldownOnDisable;
    statusImage.regulationGood = regulationGood;
    statusImage.syncFrequencyMultiplier = syncFrequencyMultiplier;
    statusImage.risingRampRate = risingRampRate;
    writeSetpoint = brc_pkg::brc_setpoint_t'(regWdata);
    writeConfig = brc_pkg::brc_config_t'(regWdata);
    writeStatus = brc_pkg::brc_status_t'(regWdata);
  end

  // Mode policy and sync lock decision
  brc_mode_select u_mode_select
  (
    .config_in(configImage),
    .setpointSelectPin(setpointSelectPin),
    .syncValid(syncValid),
    .switchMode(switchMode),
    .syncLock(syncLock)
  );

  // Ramp rate and multiplier decode
  brc_ramp_map u_ramp_map
  (
    .rampCode(risingRampRate),
    .multCode(syncFrequencyMultiplier),
    .rampScale(rampScale),
    .rampSingleStep(rampSingleStep),
    .syncMultiplier(syncMultiplier)
  );

  // Register writes; supplier and status bits are not writable
  always_comb
  begin
    next_converterEnableBit = converterEnableBit;
    next_lowCode = lowCode;
    next_highCode = highCode;
    next_syncFollow = syncFollow;
    next_pinSourceSelect = pinSourceSelect;
    next_modePolicy = modePolicy;
    next_highSetpointModeBit = highSetpointModeBit;
    next_lowSetpointModeBit = lowSetpointModeBit;
    next_transitionTrigger = transitionTrigger;
    next_outputPulldownOnDisable = outputPulldownOnDisable;
    next_syncFrequencyMultiplier = syncFrequencyMultiplier;
    next_risingRampRate = risingRampRate;
    triggerWrite = 1'b0;
    if (regWrite)
    begin
      if (addrIs(regAddr, `BRC_ADDR_LOW_SETPOINT))
      begin
        next_converterEnableBit = writeSetpoint.converterEnableBit;
        next_lowCode = writeSetpoint.code;
      end
      else if (addrIs(regAddr, `BRC_ADDR_HIGH_SETPOINT))
      begin
        next_converterEnableBit = writeSetpoint.converterEnableBit;
        next_highCode = writeSetpoint.code;
      end
      else if (addrIs(regAddr, `BRC_ADDR_CONVERTER_CONFIG))
      begin
        // Supplier bits dropped here
        next_syncFollow = writeConfig.syncFollow;
        next_pinSourceSelect = writeConfig.pinSourceSelect;
        next_modePolicy = writeConfig.modePolicy;
        next_highSetpointModeBit = writeConfig.highSetpointModeBit;
        next_lowSetpointModeBit = writeConfig.lowSetpointModeBit;
      end
      else if (addrIs(regAddr, `BRC_ADDR_TRANSITION_STATUS))
      begin
        next_transitionTrigger = writeStatus.transitionTrigger;
        next_outputPulldownOnDisable = writeStatus.outputPulldownOnDisable;
        next_syncFrequencyMultiplier = writeStatus.syncFrequencyMultiplier;
        next_risingRampRate = writeStatus.risingRampRate;
        // Each written 1 counts, even over a stored 1
        triggerWrite = writeStatus.transitionTrigger;
      end
    end
  end

  // Applied set point, transition start and regulation status
  always_comb
  begin
    next_appliedCode = appliedCode;
    next_transitionStart = 1'b0;
    if (triggerWrite && !pinSourceSelect)
    begin
      next_appliedCode = highCode;
      next_transitionStart = 1'b1;
    end
    next_regulationGood = inRegulation && !inCurrentLimit;
  end

  // Controls presented to the converter
  always_comb
  begin
    next_convCtrl.converterEnable = converterEnableBit && enablePin;
    next_convCtrl.outputPulldown = outputPulldownOnDisable &&
                                   !(converterEnableBit && enablePin);
    if (pinSourceSelect)
    begin
      if (setpointSelectPin)
        next_convCtrl.setpointCode = highCode;
      else
        next_convCtrl.setpointCode = lowCode;
    end
    else
      next_convCtrl.setpointCode = appliedCode;
    next_convCtrl.switchMode = switchMode;
    next_convCtrl.syncLock = syncLock;
    next_convCtrl.syncMultiplier = syncMultiplier;
    next_convCtrl.rampScale = rampScale;
    next_convCtrl.rampSingleStep = rampSingleStep;
  end

  // Read data; unmapped addresses read zero
  always_comb
  begin
    next_regRdata = regRdata;
    if (regRead)
    begin
      if (addrIs(regAddr, `BRC_ADDR_LOW_SETPOINT))
        next_regRdata = lowImage;
      else if (addrIs(regAddr, `BRC_ADDR_HIGH_SETPOINT))
        next_regRdata = highImage;
      else if (addrIs(regAddr, `BRC_ADDR_CONVERTER_CONFIG))
        next_regRdata = configImage;
      else if (addrIs(regAddr, `BRC_ADDR_TRANSITION_STATUS))
        next_regRdata = statusImage;
      else
        next_regRdata = `BRC_UNMAPPED_READ;
    end
  end

  // Register state
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      converterEnableBit <= `BRC_RST_ENABLE;
      lowCode <= `BRC_RST_LOW_CODE;
      highCode <= `BRC_RST_HIGH_CODE;
      syncFollow <= `BRC_RST_SYNC_FOLLOW;
      pinSourceSelect <= `BRC_RST_PIN_SOURCE;
      modePolicy <= `BRC_RST_MODE_POLICY;
      highSetpointModeBit <= `BRC_RST_HIGH_MODE;
      lowSetpointModeBit <= `BRC_RST_LOW_MODE;
      transitionTrigger <= `BRC_RST_TRIGGER;
      outputPulldownOnDisable <= `BRC_RST_PULLDOWN;
      syncFrequencyMultiplier <= `BRC_RST_MULT;
      risingRampRate <= `BRC_RST_RAMP;
      regulationGood <= `BRC_RST_GOOD;
      appliedCode <= `BRC_RST_HIGH_CODE;
    end
    else
    begin
      converterEnableBit <= next_converterEnableBit;
      lowCode <= next_lowCode;
      highCode <= next_highCode;
      syncFollow <= next_syncFollow;
      pinSourceSelect <= next_pinSourceSelect;
      modePolicy <= next_modePolicy;
      highSetpointModeBit <= next_highSetpointModeBit;
      lowSetpointModeBit <= next_lowSetpointModeBit;
      transitionTrigger <= next_transitionTrigger;
      outputPulldownOnDisable <= next_outputPulldownOnDisable;
      syncFrequencyMultiplier <= next_syncFrequencyMultiplier;
      risingRampRate <= next_risingRampRate;
      regulationGood <= next_regulationGood;
      appliedCode <= next_appliedCode;
    end
  end

  // Output registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdata <= `BRC_UNMAPPED_READ;
      convCtrl <= '0;
      transitionStart <= 1'b0;
    end
    else
    begin
      regRdata <= next_regRdata;
      convCtrl <= next_convCtrl;
      transitionStart <= next_transitionStart;
    end
  end

endmodule
`default_nettype wire

// >>> tb/brc_control_regs_assertions.sv
// Concurrent checks on the regulator control register bank
`timescale 1ns/100ps
`default_nettype none
`include "brc_defines.svh"

module brc_control_regs_assertions
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic enablePin,
  input wire logic syncValid,
  input wire logic inCurrentLimit,
  input wire brc_pkg::brc_conv_ctrl_t convCtrl,
  input wire logic transitionStart
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Trigger write seen on the register port
  logic trigWr;
  assign trigWr = regWrite && regAddr == 8'h03 && regWdata[7];

  property p_supplierCode;
    regRead && regAddr == 8'h02 |=> regRdata[7:6] == `BRC_SUPPLIER_CODE;
  endproperty
  a_supplierCode: assert property (p_supplierCode)
    else $error("supplier bits wrong");

  property p_syncIgnored;
    !syncValid [*2] |=> !convCtrl.syncLock;
  endproperty
  a_syncIgnored: assert property (p_syncIgnored)
    else $error("lock without sync");

  property p_lockFixed;
    convCtrl.syncLock |-> convCtrl.switchMode == brc_pkg::BRC_MODE_FIXED_FREQ;
  endproperty
  a_lockFixed: assert property (p_lockFixed)
    else $error("light load while locked");

  property p_startCause;
    transitionStart |-> $past(trigWr);
  endproperty
  a_startCause: assert property (p_startCause)
    else $error("start without trigger");

  property p_startPulse;
    transitionStart && !trigWr |=> !transitionStart;
  endproperty
  a_startPulse: assert property (p_startPulse)
    else $error("start too long");

  property p_pulldownOff;
    convCtrl.outputPulldown |-> !convCtrl.converterEnable;
  endproperty
  a_pulldownOff: assert property (p_pulldownOff)
    else $error("pulldown while enabled");

  property p_limitGood;
    inCurrentLimit [*3] ##0 (regRead && regAddr == 8'h03) |=> !regRdata[5];
  endproperty
  a_limitGood: assert property (p_limitGood)
    else $error("good during limit");

  property p_multRange;
    $past(rst_n) |-> convCtrl.syncMultiplier inside {[3'h1:3'h4]};
  endproperty
  a_multRange: assert property (p_multRange)
    else $error("multiplier out of range");

  property p_rampMap;
    $past(rst_n) |-> (convCtrl.rampSingleStep ? convCtrl.rampScale == 7'h00
      : $onehot(convCtrl.rampScale));
  endproperty
  a_rampMap: assert property (p_rampMap)
    else $error("ramp decode wrong");

  property p_pinEnable;
    !enablePin [*2] |=> !convCtrl.converterEnable;
  endproperty
  a_pinEnable: assert property (p_pinEnable)
    else $error("enabled with pin low");

  property p_unmapped;
    regRead && regAddr > 8'h03 |=> regRdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  // Main scenarios reached
  c_start: cover property (transitionStart);
  c_lock: cover property (convCtrl.syncLock);
  c_single: cover property (convCtrl.rampSingleStep && convCtrl.syncLock);
endmodule

bind brc_control_regs brc_control_regs_assertions u_brc_control_regs_assertions
(
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .regWrite(regWrite),
  .regRead(regRead),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regRdata(regRdata),
  .enablePin(enablePin),
  .syncValid(syncValid),
  .inCurrentLimit(inCurrentLimit),
  .convCtrl(convCtrl),
  .transitionStart(transitionStart)
);
`default_nettype wire

// >>> tb/brc_host_model.sv
// Host model issuing byte accesses on the register port
`timescale 1ns/100ps
`default_nettype none

module brc_host_model
(
  input wire logic ref_clk,
  input wire logic [7:0] regRdata,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata
);
  int gap = 0;

  // Idle port at time zero
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end

  // One byte write, released lines inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    repeat (gap) @(negedge ref_clk);
    @(negedge ref_clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge ref_clk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask

  // One byte read, data taken after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    repeat (gap) @(negedge ref_clk);
    @(negedge ref_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge ref_clk);
    regRead = 1'b0;
    regAddr = ~a;
    d = regRdata;
  endtask
endmodule
`default_nettype wire

// >>> tb/brc_control_regs_tb.sv
// Self-checking bench for the regulator control register bank
`timescale 1ns/100ps
`default_nettype none

module brc_control_regs_tb;
  logic ref_clk;
  logic rst_n;
  logic regWrite;
  logic regRead;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic setpointSelectPin;
  logic enablePin;
  logic syncValid;
  logic inRegulation;
  logic inCurrentLimit;
  brc_pkg::brc_conv_ctrl_t convCtrl;
  logic transitionStart;
  int fail_count = 0;
  int n_tests = 0;
  logic [7:0] d;
  logic [7:0] img [5] = '{8'hD8, 8'hF0, 8'h50, 8'h27, 8'h00};
  logic [7:0] modeCfg [6] = '{8'h40, 8'h42, 8'h44, 8'h48, 8'h4C, 8'h4E};
  logic [5:0] modeExp = 6'h26;

  brc_control_regs u_brc_control_regs
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .regWrite(regWrite),
    .regRead(regRead),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regRdata(regRdata),
    .setpointSelectPin(setpointSelectPin),
    .enablePin(enablePin),
    .syncValid(syncValid),
    .inRegulation(inRegulation),
    .inCurrentLimit(inCurrentLimit),
    .convCtrl(convCtrl),
    .transitionStart(transitionStart)
  );

  brc_host_model u_brc_host_model
  (
    .ref_clk(ref_clk),
    .regRdata(regRdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regAddr(regAddr),
    .regWdata(regWdata)
  );

  // Free-running 50 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic complete_run();
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #1000000;
    fail_count++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    setpointSelectPin = 1'b1;
    enablePin = 1'b1;
    syncValid = 1'b0;
    inRegulation = 1'b1;
    inCurrentLimit = 1'b0;
    idle(16);
    rst_n = 1'b1;
    idle(3);
    for (int i = 0; i < 5; i++)
    begin
      u_brc_host_model.rd(i[7:0], d);
      chk(d, img[i]);
    end
    // Unmapped write must leave the low set point alone
    u_brc_host_model.wr(8'h04, 8'h00);
    u_brc_host_model.rd(8'h00, d);
    chk(d, 8'hD8);
    u_brc_host_model.wr(8'h02, 8'hFF);
    u_brc_host_model.rd(8'h02, d);
    chk(d, 8'h7F);
    u_brc_host_model.wr(8'h02, 8'h50);
    idle(2);
    chk({2'h0, convCtrl.setpointCode}, 8'h30);
    chk({7'h0, convCtrl.switchMode}, 8'h00);
    setpointSelectPin = 1'b0;
    syncValid = 1'b1;
    idle(2);
    chk({2'h0, convCtrl.setpointCode}, 8'h18);
    chk({7'h0, convCtrl.switchMode}, 8'h01);
    chk({7'h0, convCtrl.syncLock}, 8'h00);
    // Sync follow: exception with pin low, lock with pin high
    u_brc_host_model.wr(8'h02, 8'h72);
    idle(2);
    chk({6'h0, convCtrl.syncLock, convCtrl.switchMode}, 8'h01);
    setpointSelectPin = 1'b1;
    idle(2);
    chk({6'h0, convCtrl.syncLock, convCtrl.switchMode}, 8'h02);
    // Slow host for the multiplier codes
    u_brc_host_model.gap = 3;
    for (int m = 0; m < 4; m++)
    begin
      u_brc_host_model.wr(8'h03, {3'h0, m[1:0], 3'h7});
      idle(2);
      chk({5'h0, convCtrl.syncMultiplier}, 8'(m + 1));
    end
    u_brc_host_model.gap = 0;
    for (int r = 0; r < 8; r++)
    begin
      u_brc_host_model.wr(8'h03, {5'h0, r[2:0]});
      idle(2);
      d = (r == 7) ? 8'h80 : 8'(1 << r);
      chk({convCtrl.rampSingleStep, convCtrl.rampScale}, d);
    end
    // Software source: policies with the pin ignored
    syncValid = 1'b0;
    u_brc_host_model.wr(8'h02, 8'h40);
    idle(2);
    setpointSelectPin = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      u_brc_host_model.wr(8'h02, modeCfg[i]);
      idle(2);
      chk({7'h0, convCtrl.switchMode}, {7'h0, modeExp[i]});
    end
    u_brc_host_model.wr(8'h01, 8'h85);
    idle(2);
    chk({2'h0, convCtrl.setpointCode}, 8'h30);
    u_brc_host_model.wr(8'h03, 8'h87);
    chk({7'h0, transitionStart}, 8'h01);
    idle(1);
    chk({1'b0, transitionStart, convCtrl.setpointCode}, 8'h05);
    u_brc_host_model.rd(8'h03, d);
    chk(d, 8'hA7);
    u_brc_host_model.wr(8'h01, 8'h8A);
    u_brc_host_model.wr(8'h03, 8'h87);
    chk({7'h0, transitionStart}, 8'h01);
    idle(1);
    chk({2'h0, convCtrl.setpointCode}, 8'h0A);
    // Pin source again: trigger ignored
    u_brc_host_model.wr(8'h02, 8'h50);
    u_brc_host_model.wr(8'h03, 8'h87);
    chk({7'h0, transitionStart}, 8'h00);
    idle(1);
    chk({2'h0, convCtrl.setpointCode}, 8'h18);
    // Shared enable and output pulldown
    u_brc_host_model.wr(8'h00, 8'h18);
    u_brc_host_model.rd(8'h01, d);
    chk(d, 8'h4A);
    u_brc_host_model.wr(8'h03, 8'h67);
    idle(2);
    chk({6'h0, convCtrl.converterEnable, convCtrl.outputPulldown},
        8'h01);
    u_brc_host_model.wr(8'h01, 8'h8A);
    idle(2);
    chk({6'h0, convCtrl.converterEnable, convCtrl.outputPulldown},
        8'h02);
    enablePin = 1'b0;
    inCurrentLimit = 1'b1;
    idle(3);
    chk({6'h0, convCtrl.converterEnable, convCtrl.outputPulldown},
        8'h01);
    u_brc_host_model.rd(8'h03, d);
    chk(d, 8'h47);
    // Out of regulation alone clears the status bit, then recovery
    inCurrentLimit = 1'b0;
    inRegulation = 1'b0;
    idle(2);
    u_brc_host_model.rd(8'h03, d);
    chk(d, 8'h47);
    inRegulation = 1'b1;
    idle(2);
    u_brc_host_model.rd(8'h03, d);
    chk(d, 8'h67);
    complete_run();
  end
endmodule
`default_nettype wire
